// *** usdp_asserts.sv ***
/* Port checks of the shadow data port.
   Assumes a bind onto usdp_shadow_port. */
`timescale 1ns/1ns
module usdp_asserts (
    // Clock, reset and bus
    input wire logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
    input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
    input wire logic [3:0]  wb_sel_i,
    // Shifter side and interrupt
    input wire logic        rx_valid, tx_pop, tx_avail, ir_mode, irq,
    input wire logic [7:0]  rx_byte, tx_byte
);
    // New request, aligned alias hit, any write
    wire logic [31:0] off = wb_adr_i - usdp_pkg::ALIAS_BASE;
    wire logic        req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic        hit = off < usdp_pkg::ALIAS_SPAN && off[1:0] == 2'h0;
    wire logic        wr  = wb_cyc_i && wb_we_i;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ans_next_a: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no answer");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    alias_ack_a: assert property (req && hit |=> wb_ack_o)
        else $error("alias refused");
    high_zero_a: assert property (wb_ack_o && !wb_we_i && hit |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits set");
    tx_load_a: assert property (wb_ack_o && wb_we_i && hit && wb_sel_i[0] && !tx_pop |=> tx_avail)
        else $error("byte not queued");
    tx_hold_a: assert property (tx_avail && !tx_pop && !wr |=> tx_avail && $stable(tx_byte))
        else $error("queued byte changed");
    mode_keep_a: assert property (!wr |=> $stable(ir_mode)) else $error("mode moved");
    irq_quiet_a: assert property (!irq && !rx_valid && !tx_pop && !wr
        && !$past(rx_valid || tx_pop) |=> !irq) else $error("irq without event");
    // Main scenarios
    err_seen_c: cover property (wb_err_o);
    pop_seen_c: cover property (tx_pop && tx_avail);
    irq_rise_c: cover property ($rose(irq));
endmodule
bind usdp_shadow_port usdp_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_sel_i(wb_sel_i), .rx_valid(rx_valid), .tx_pop(tx_pop), .tx_avail(tx_avail),
    .ir_mode(ir_mode), .irq(irq), .rx_byte(rx_byte), .tx_byte(tx_byte));

// *** usdp_peer.sv ***
/* Shifter model on the far side of the port.
   Assumes the bench sets take_en and calls send. */
`timescale 1ns/1ns
module usdp_peer (
    // Clock and shifter side
    input  wire logic       sys_clk,
    input  wire logic       tx_avail,
    input  wire logic [7:0] tx_byte,
    output logic            tx_pop = 1'h0,
    output logic            rx_valid = 1'h0,
    output logic [7:0]      rx_byte = 8'h00
);
    logic       take_en = 1'h0;
    logic [7:0] seen [0:31];
    int         n_seen = 0;
    // Slow shifter: one byte every other cycle, stalls while take_en is low
    always @(posedge sys_clk) begin
        if (tx_pop && tx_avail) begin
            seen[n_seen] <= tx_byte;
            n_seen <= n_seen + 1;
        end
        tx_pop <= take_en && tx_avail && !tx_pop;
    end
    // One received byte; the data lines then flip so nothing stale lingers
    task automatic send(input logic [7:0] b);
        @(posedge sys_clk);
        rx_valid <= 1'h1;
        rx_byte <= b;
        @(posedge sys_clk);
        rx_valid <= 1'h0;
        rx_byte <= ~b;
    endtask
endmodule

// *** usdp_pkg.sv ***
/*
 * Constants for the shadow data-port block: register offsets, field
 * positions, reset values and FIFO sizing.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package usdp_pkg;
    // Shadow alias window: sixteen word-spaced locations
    localparam logic [31:0] ALIAS_BASE     = 32'h50001030;
    localparam logic [31:0] ALIAS_12_ADDR  = 32'h50001060;
    localparam logic [31:0] ALIAS_13_ADDR  = 32'h50001064;
    localparam int          ALIAS_COUNT    = 16;
    localparam logic [31:0] ALIAS_SPAN     = 32'h00000040;
    // Control, status and interrupt registers
    localparam logic [31:0] FIFO_CTRL_ADDR = 32'h50001100;
    localparam logic [31:0] LINE_STAT_ADDR = 32'h50001104;
    localparam logic [31:0] IRQ_STAT_ADDR  = 32'h50001108;
    localparam logic [31:0] IRQ_MASK_ADDR  = 32'h5000110C;
    localparam logic [31:0] RX_IN_ADDR     = 32'h50001110;
    localparam logic [31:0] TX_POP_ADDR    = 32'h50001114;
    // Field positions
    localparam int FCR_FIFO_EN_BIT  = 0;
    localparam int FCR_IR_MODE_BIT  = 1;
    localparam int LSR_DR_BIT       = 0;
    localparam int LSR_OE_BIT       = 1;
    localparam int LSR_TX_HOLDING_EMPTY_FLAG_BIT     = 5;
    localparam int IRQ_OVERRUN_BIT  = 0;
    localparam int IRQ_RX_BIT       = 1;
    localparam int IRQ_TXE_BIT      = 2;
    localparam int IRQ_WIDTH        = 3;
    // Sizes and reset values
    localparam int          FIFO_DEPTH   = 16;
    localparam int          PTR_W        = 4;
    localparam int          CNT_W        = 5;
    localparam logic [7:0]  DATA_RESET   = 8'h00;
    localparam logic [15:0] ALIAS_RESET  = 16'h0000;
    localparam logic [31:0] ZERO_WORD    = 32'h00000000;
endpackage

// *** usdp_shadow_port.sv ***
/*
 * Shadow data-port of an asynchronous serial port, with its receive and
 * transmit storage, line status, overrun reporting and interrupt.
 * Assumes a classic Wishbone master on sys_clk and a receiver/transmitter
 * shifter outside that presents received bytes and drains bytes to send.
 * Limitations: FIFO depth is fixed at sixteen; a full transmit FIFO
 * drops writes instead of stalling the bus, so software must watch
 * transmit-holding-empty. Reading an empty alias returns the stale head.
 * Baud timing, line control and the serial shifter itself live outside.
 */
// Notes on behaviour
// [R01] Receive buffer and transmit holding register appear at sixteen word-spaced aliases.
// [R02] Alias reads return the received byte in bits 7:0, plain or infrared.
// [R03] Software trusts the received byte only while data-ready is set.
// [R04] FIFOs off: a new byte overwrites an unread one and raises overrun.
// [R05] FIFOs on: alias reads return the head of the receive FIFO.
// [R06] Receive FIFO full: keep contents, drop the new byte, raise overrun.
// [R07] Alias writes queue a byte for the serial or inverted infrared output.
// [R08] Software writes transmit data only while transmit-holding-empty is set.
// [R09] FIFOs off: one written byte clears transmit-holding-empty.
// [R10] FIFOs off: further writes before empty returns overwrite pending data.
// [R11] FIFOs on: sixteen bytes are accepted before the transmit FIFO is full.
// [R12] Writes to a full transmit FIFO are dropped, contents unchanged.
// [R13] Alias bits 15:8 read zero and ignore writes.
`timescale 1ns/1ns
module usdp_shadow_port (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Receive side from the shifter
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    // Transmit side to the shifter
    input  wire logic        tx_pop,
    output logic      [7:0]  tx_byte,
    output logic             tx_avail,
    output logic             ir_mode,
    // Interrupt
    output logic             irq
);
    // Storage arrays
    logic [7:0] rx_mem [usdp_pkg::FIFO_DEPTH];
    logic [7:0] tx_mem [usdp_pkg::FIFO_DEPTH];

    // Receive FIFO pointers and fill count
    logic [usdp_pkg::PTR_W-1:0]     rx_rd_reg;
    logic [usdp_pkg::PTR_W-1:0]     rx_wr_reg;
    logic [usdp_pkg::CNT_W-1:0]     rx_cnt_reg;
    logic [usdp_pkg::CNT_W-1:0]     rx_cnt_next;
    // Transmit FIFO pointers and fill count
    logic [usdp_pkg::PTR_W-1:0]     tx_rd_reg;
    logic [usdp_pkg::PTR_W-1:0]     tx_wr_reg;
    logic [usdp_pkg::CNT_W-1:0]     tx_cnt_reg;
    logic [usdp_pkg::CNT_W-1:0]     tx_cnt_next;
    // Pointer next values, one step ahead of each pointer
    logic [usdp_pkg::PTR_W-1:0]     rx_rd_next;
    logic [usdp_pkg::PTR_W-1:0]     rx_wr_next;
    logic [usdp_pkg::PTR_W-1:0]     tx_rd_next;
    logic [usdp_pkg::PTR_W-1:0]     tx_wr_next;
    // Single-byte holding used with FIFOs off
    logic [7:0]                     rx_buffer_reg;
    logic [7:0]                     tx_holding_reg;
    logic                           rx_full_flag_reg;
    logic                           tx_full_flag_reg;
    // Control, line status and interrupt state
    logic [1:0]                     fifo_control_reg;
    logic                           overrun_reg;
    logic [usdp_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
    logic [usdp_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
    logic [usdp_pkg::IRQ_WIDTH-1:0] irq_stat_next;
    // Registered bus answer
    logic                           ack_reg;
    logic                           err_reg;
    logic [31:0]                    dat_reg;

    // Address decode
    function automatic logic is_alias(input logic [31:0] a);
        return (a >= usdp_pkg::ALIAS_BASE) &&
               (a < usdp_pkg::ALIAS_BASE + usdp_pkg::ALIAS_SPAN) && (a[1:0] == 2'h0);
    endfunction

    // Pointer step, wrapping naturally at the power-of-two depth
    function automatic logic [usdp_pkg::PTR_W-1:0] next_ptr(
        input logic [usdp_pkg::PTR_W-1:0] p);
        return p + usdp_pkg::PTR_W'(1);
    endfunction

    // FIFO full test on a fill count
    function automatic logic cnt_full(input logic [usdp_pkg::CNT_W-1:0] c);
        return c == usdp_pkg::CNT_W'(usdp_pkg::FIFO_DEPTH);
    endfunction

    wire req         = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    wire hit_alias   = is_alias(wb_adr_i); // R01
    wire hit_fcr     = wb_adr_i == usdp_pkg::FIFO_CTRL_ADDR;
    wire hit_lsr     = wb_adr_i == usdp_pkg::LINE_STAT_ADDR;
    wire hit_ist     = wb_adr_i == usdp_pkg::IRQ_STAT_ADDR;
    wire hit_imk     = wb_adr_i == usdp_pkg::IRQ_MASK_ADDR;
    wire hit_any     = hit_alias || hit_fcr || hit_lsr || hit_ist || hit_imk;
    wire wr_alias    = req && wb_we_i && hit_alias && wb_sel_i[0]; // R13
    wire rd_alias    = req && !wb_we_i && hit_alias;
    wire rd_lsr      = req && !wb_we_i && hit_lsr;
    wire fifo_en     = fifo_control_reg[usdp_pkg::FCR_FIFO_EN_BIT];
    // Register write strobes; only byte lane 0 carries writable bits
    wire wr_fcr      = req && wb_we_i && hit_fcr && wb_sel_i[0];
    wire wr_imk      = req && wb_we_i && hit_imk && wb_sel_i[0];
    wire wr_ist      = req && wb_we_i && hit_ist && wb_sel_i[0];

    // Status flags seen by software
    wire data_ready_flag       = fifo_en ? (rx_cnt_reg != '0) : rx_full_flag_reg; // R03
    wire tx_holding_empty_flag = fifo_en ? (tx_cnt_reg == '0) : !tx_full_flag_reg; // R08
    // Line status byte: ready in bit 0, overrun in bit 1, empty in bit 5
    wire [7:0] line_status_reg = {2'h0, tx_holding_empty_flag, 3'h0, overrun_reg,
                                  data_ready_flag};

    // Receive events
    wire rx_fifo_full = cnt_full(rx_cnt_reg);
    wire rx_pop       = rd_alias && data_ready_flag;
    wire rx_push      = rx_valid && fifo_en && (!rx_fifo_full || rx_pop); // R06
    wire rx_over      = rx_valid && (fifo_en ? (rx_fifo_full && !rx_pop)   // R06
                                             : (rx_full_flag_reg && !rx_pop)); // R04
    wire [7:0] rx_head = fifo_en ? rx_mem[rx_rd_reg] : rx_buffer_reg; // R05

    // Transmit events; a full FIFO drops writes rather than stalling the bus
    wire tx_fifo_full = cnt_full(tx_cnt_reg); // R11
    wire tx_push      = wr_alias && fifo_en && !tx_fifo_full; // R12
    wire tx_take      = tx_pop && tx_avail;
    wire tx_fpop      = tx_take && fifo_en;

    // Transmit side outputs towards the shifter
    assign tx_avail = fifo_en ? (tx_cnt_reg != '0) : tx_full_flag_reg;
    assign ir_mode  = fifo_control_reg[usdp_pkg::FCR_IR_MODE_BIT]; // R07
    assign tx_byte  = fifo_en ? tx_mem[tx_rd_reg] : tx_holding_reg; // R07

    // Fill counts move by one push and one pop per cycle
    assign rx_cnt_next = rx_cnt_reg + usdp_pkg::CNT_W'(rx_push)
                         - usdp_pkg::CNT_W'(rx_pop && fifo_en);
    assign tx_cnt_next = tx_cnt_reg + usdp_pkg::CNT_W'(tx_push)
                         - usdp_pkg::CNT_W'(tx_fpop);

    // Pointer next values
    assign rx_rd_next = next_ptr(rx_rd_reg);
    assign rx_wr_next = next_ptr(rx_wr_reg);
    assign tx_rd_next = next_ptr(tx_rd_reg);
    assign tx_wr_next = next_ptr(tx_wr_reg);

    // Interrupt sources; set wins over a write-one clear
    wire [usdp_pkg::IRQ_WIDTH-1:0] irq_set = {tx_take, rx_valid, rx_over};
    wire [usdp_pkg::IRQ_WIDTH-1:0] irq_clr =
        wr_ist ? wb_dat_i[usdp_pkg::IRQ_WIDTH-1:0] : '0;
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    // Level interrupt from unmasked sticky bits
    assign irq           = |(irq_stat_reg & irq_mask_reg);

    // Read words per register; the alias upper byte stays zero
    wire [31:0] alias_word = {24'h0, rx_head}; // R02 R13
    wire [31:0] fcr_word   = {30'h0, fifo_control_reg};
    wire [31:0] lsr_word   = {24'h0, line_status_reg};
    wire [31:0] ist_word   = {29'h0, irq_stat_reg};
    wire [31:0] imk_word   = {29'h0, irq_mask_reg};
    // Read data selection
    wire [31:0] rd_data =
        hit_alias ? alias_word :
        hit_fcr   ? fcr_word :
        hit_lsr   ? lsr_word :
        hit_ist   ? ist_word :
        hit_imk   ? imk_word : usdp_pkg::ZERO_WORD;

    // Bus answer one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req && hit_any;
        end
    end

    // Unmapped or unaligned addresses get err and have no effect
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= req && !hit_any;
        end
    end

    // Read data stands only in the answer cycle, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dat_reg <= usdp_pkg::ZERO_WORD;
        end else begin
            dat_reg <= req ? rd_data : usdp_pkg::ZERO_WORD;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = dat_reg;

    // FIFO enable and infrared mode control
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fifo_control_reg <= 2'h0;
        end else if (wr_fcr) begin
            fifo_control_reg <= wb_dat_i[1:0];
        end
    end

    // Interrupt mask, one enable per status bit
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_mask_reg <= '0;
        end else if (wr_imk) begin
            irq_mask_reg <= wb_dat_i[usdp_pkg::IRQ_WIDTH-1:0];
        end
    end

    // Sticky interrupt status
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Overrun flag clears on a line status read; a new overrun wins
    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            overrun_reg <= 1'b0;
        else if (rx_over)
            overrun_reg <= 1'b1; // R04 R06
        else if (rd_lsr)
            overrun_reg <= 1'b0;
    end

    // Single receive buffer used with FIFOs off; a new byte overwrites
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rx_buffer_reg <= usdp_pkg::DATA_RESET;
        end else if (!fifo_en && rx_valid) begin
            rx_buffer_reg <= rx_byte; // R04
        end
    end

    // Data ready of the single buffer; an arriving byte wins over a read
    always_ff @(posedge sys_clk) begin
        if (!rst_b || fifo_en) begin
            rx_full_flag_reg <= 1'b0;
        end else if (rx_valid) begin
            rx_full_flag_reg <= 1'b1;
        end else if (rx_pop) begin
            rx_full_flag_reg <= 1'b0;
        end
    end

    // Single transmit holding register used with FIFOs off
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tx_holding_reg <= usdp_pkg::DATA_RESET;
        end else if (!fifo_en && wr_alias) begin
            tx_holding_reg <= wb_dat_i[7:0]; // R10
        end
    end

    // Holding-full flag; a write wins over a shifter take in one cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b || fifo_en) begin
            tx_full_flag_reg <= 1'b0;
        end else if (wr_alias) begin
            tx_full_flag_reg <= 1'b1; // R09
        end else if (tx_take) begin
            tx_full_flag_reg <= 1'b0;
        end
    end

    // Receive FIFO fill count; turning FIFOs off flushes it
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !fifo_en) begin
            rx_cnt_reg <= '0;
        end else begin
            rx_cnt_reg <= rx_cnt_next;
        end
    end

    // Receive FIFO write pointer
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !fifo_en) begin
            rx_wr_reg <= '0;
        end else if (rx_push) begin
            rx_wr_reg <= rx_wr_next;
        end
    end

    // Receive FIFO read pointer, advanced by an alias read
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !fifo_en) begin
            rx_rd_reg <= '0;
        end else if (rx_pop) begin
            rx_rd_reg <= rx_rd_next; // R05
        end
    end

    // Receive storage; no reset, as only counted entries are read
    always_ff @(posedge sys_clk) begin
        if (rx_push)
            rx_mem[rx_wr_reg] <= rx_byte;
    end

    // Transmit FIFO fill count; turning FIFOs off flushes it
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !fifo_en) begin
            tx_cnt_reg <= '0;
        end else begin
            tx_cnt_reg <= tx_cnt_next; // R11
        end
    end

    // Transmit FIFO write pointer
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !fifo_en) begin
            tx_wr_reg <= '0;
        end else if (tx_push) begin
            tx_wr_reg <= tx_wr_next;
        end
    end

    // Transmit FIFO read pointer, advanced by a shifter take
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !fifo_en) begin
            tx_rd_reg <= '0;
        end else if (tx_fpop) begin
            tx_rd_reg <= tx_rd_next;
        end
    end

    // Transmit storage; no reset, as only counted entries are sent
    always_ff @(posedge sys_clk) begin
        if (tx_push)
            tx_mem[tx_wr_reg] <= wb_dat_i[7:0]; // R07
    end
endmodule

// *** usdp_shadow_port_tb.sv ***
/* Self-checking bench of the shadow data port.
   Assumes usdp_pkg, usdp_peer and the checker are compiled first. */
`timescale 1ns/1ns
module usdp_shadow_port_tb;
    logic             sys_clk = 1'h0, rst_b = 1'h0, cyc = 1'h0, we = 1'h0, berr;
    logic [31:0]      adr = 32'h0, dat = 32'h0, d, seed = 32'h60;
    logic [3:0]       sel = 4'hF, lanes = 4'hF;
    logic [7:0]       q [0:16];
    wire logic [31:0] dat_o;
    wire logic [7:0]  rxb, txb;
    wire logic        ack, err, rxv, pop, txa, irm, irq;
    int               miscompares = 0, n_compared = 0, i;
    always #5 sys_clk = ~sys_clk;
    usdp_shadow_port dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .rx_valid(rxv), .rx_byte(rxb), .tx_pop(pop),
        .tx_byte(txb), .tx_avail(txa), .ir_mode(irm), .irq(irq));
    usdp_peer peer (.sys_clk(sys_clk), .tx_avail(txa), .tx_byte(txb), .tx_pop(pop),
        .rx_valid(rxv), .rx_byte(rxb));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic cycle, held until ack or err is sampled; settles at the falling edge
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        dat <= v;
        sel <= lanes;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'h1 && err !== 1'h1 && n < 20);
        d = dat_o;
        berr = err;
        cyc <= 1'h0;
        if (n >= 20) begin
            miscompares++;
            close_out();
        end
        @(negedge sys_clk);
    endtask
    task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk(nm, e, d);
    endtask
    // Expected line status from ready, overrun and holding-empty
    task automatic stat(input logic rdy, input logic ovr, input logic emp);
        rc("status", usdp_pkg::LINE_STAT_ADDR, {26'h0, emp, 3'h0, ovr, rdy});
    endtask
    task automatic drain();
        for (int n = 0; n < 200 && txa === 1'h1; n++) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'h1;
        rc("alias12", usdp_pkg::ALIAS_12_ADDR, 32'h0);
        stat(1'h0, 1'h0, 1'h1);
        wb(1'h1, usdp_pkg::ALIAS_BASE + 32'h2, 32'h0);
        chk("err", 32'h1, 32'(berr));
        wb(1'h1, usdp_pkg::ALIAS_12_ADDR, 32'hA55A);
        stat(1'h0, 1'h0, 1'h0);
        seed = xs(seed);
        wb(1'h1, usdp_pkg::ALIAS_13_ADDR, seed);
        lanes = 4'hE;
        wb(1'h1, usdp_pkg::ALIAS_12_ADDR, 32'h11);
        lanes = 4'hF;
        chk("tx_byte", 32'(seed[7:0]), 32'(txb));
        peer.take_en <= 1'h1;
        drain();
        chk("sent", {24'h1, seed[7:0]}, {peer.n_seen[23:0], peer.seen[0]});
        stat(1'h0, 1'h0, 1'h1);
        peer.send(8'h3C);
        peer.send(8'hC3);
        stat(1'h1, 1'h1, 1'h1);
        rc("rx", usdp_pkg::ALIAS_13_ADDR, 32'hC3);
        stat(1'h0, 1'h0, 1'h1);
        chk("irq", 32'h0, 32'(irq));
        wb(1'h1, usdp_pkg::IRQ_MASK_ADDR, 32'h2);
        chk("irq", 32'h1, 32'(irq));
        wb(1'h1, usdp_pkg::IRQ_STAT_ADDR, 32'h7);
        chk("irq", 32'h0, 32'(irq));
        rc("irq_stat", usdp_pkg::IRQ_STAT_ADDR, 32'h0);
        wb(1'h1, usdp_pkg::FIFO_CTRL_ADDR, 32'h3);
        chk("ir_mode", 32'h1, 32'(irm));
        peer.take_en <= 1'h0;
        for (i = 0; i < 17; i++) begin
            seed = xs(seed);
            q[i] = seed[7:0];
            wb(1'h1, usdp_pkg::ALIAS_BASE + 32'(4 * (i % 16)), seed);
        end
        peer.take_en <= 1'h1;
        drain();
        chk("pops", 32'h11, peer.n_seen);
        for (i = 0; i < 16; i++) chk("tx", 32'(q[i]), 32'(peer.seen[i + 1]));
        for (i = 0; i < 17; i++) begin
            seed = xs(seed);
            q[i] = seed[7:0];
            peer.send(q[i]);
        end
        stat(1'h1, 1'h1, 1'h1);
        for (i = 0; i < 16; i++) rc("rx", usdp_pkg::ALIAS_BASE + 32'(4 * i), 32'(q[i]));
        stat(1'h0, 1'h0, 1'h1);
        close_out();
    end
endmodule
